// file: hw/svtd_pkg.sv
`default_nettype none
package svtd_pkg;
  // register indices; the apb byte address is four times the index
  localparam logic [11:0] ctrl_index = 12'hf85; // control word, low byte used
  localparam logic [11:0] flag_index = 12'hf86; // sticky event flags, w1c
  localparam logic [11:0] mask_index = 12'hf87; // interrupt enables
  localparam logic [13:0] ctrl_addr = {ctrl_index, 2'b00};
  localparam logic [13:0] flag_addr = {flag_index, 2'b00};
  localparam logic [13:0] mask_addr = {mask_index, 2'b00};
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam int dir_bit = 7;
  localparam int bg_bit = 6;
  localparam int ref_bit = 5;
  localparam int en_bit = 4;
  localparam int lvl_lo = 0; // trip level field, low bit and width
  localparam int lvl_w = 4;
  localparam logic [3:0] ext_code = 4'hf;
  localparam int evt_bit = 0;
  // reference settling time in ns and its cycle count at 50 mhz
  localparam int settle_ns = 20000;
  localparam int clk_ns = 20;
  localparam int settle_cyc = (settle_ns + clk_ns - 1) / clk_ns;
  localparam logic [15:0] settle_max = 16'(settle_cyc);

  typedef struct packed {
    logic dir;
    logic en;
    logic [3:0] level;
  } svtd_ctrl_type;

  // analog front end controls
  typedef struct packed {
    logic power;
    logic use_ext;
    logic dir;
    logic [3:0] level;
  } svtd_ana_type;
endpackage
`default_nettype wire

// file: hw/svtd_top.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - direction bit chooses falling or rising trip
// - enable bit powers comparator and divider
// - stable flag low after enable until settled
// - stable flag read-only, shows reference state
// - events ignored until reference is stable
// - bandgap flag read-only, shows bandgap state
// - four-bit level picks one of fifteen internal trips
// - code 1111 routes external input to comparator
// - comparator trip sets event flag
// - flagged enabled event raises interrupt output
// - settling timed by counting clocks to a fixed count
// - detector runs in sleep, trip wakes device
// - reset clears control, detector off
module svtd_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_trip, // async comparator output
  input wire logic bandgap_ok,
  output var svtd_pkg::svtd_ana_type ana_ctrl,
  output logic irq,
  output logic wake
);
  svtd_pkg::svtd_ctrl_type ctrl_q, ctrl_d;
  logic [15:0] cnt_q, cnt_d;
  logic stable_q, stable_d;
  logic sync1_q, sync2_q;
  logic evt_q, evt_d;
  logic mask_q, mask_d;
  logic [31:0] rdata_d;
  logic ready_d, err_d, irq_d, wake_d;
  svtd_pkg::svtd_ana_type ana_d;
  logic acc, wr, hit;

  assign acc = psel && penable && !pready;
  assign wr = acc && pwrite;
  assign hit = (paddr == svtd_pkg::ctrl_addr) ||
    (paddr == svtd_pkg::flag_addr) || (paddr == svtd_pkg::mask_addr);

  // comparator synchroniser, two stages
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= cmp_trip;
      sync2_q <= sync1_q;
    end
  end

  // control, settle timer, flags, bus answer
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    cnt_d = cnt_q;
    stable_d = stable_q;
    evt_d = evt_q;
    if (wr && paddr == svtd_pkg::ctrl_addr) begin
      // status bits 6 and 5 are not stored
      ctrl_d.dir = pwdata[svtd_pkg::dir_bit];
      ctrl_d.en = pwdata[svtd_pkg::en_bit];
      ctrl_d.level = pwdata[svtd_pkg::lvl_lo +: svtd_pkg::lvl_w];
    end
    if (wr && paddr == svtd_pkg::mask_addr)
      mask_d = pwdata[svtd_pkg::evt_bit];
    // restart settling on every power-up, fixed time base
    if (!ctrl_q.en) begin
      cnt_d = 16'h0000;
      stable_d = 1'b0;
    end else if (!stable_q) begin
      if (cnt_q == svtd_pkg::settle_max - 16'h0001)
        stable_d = 1'b1;
      else
        cnt_d = cnt_q + 16'h0001;
    end
    // w1c clear; a trip in the same cycle wins
    if (wr && paddr == svtd_pkg::flag_addr && pwdata[svtd_pkg::evt_bit])
      evt_d = 1'b0;
    if (ctrl_q.en && stable_q && sync2_q)
      evt_d = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      svtd_pkg::ctrl_addr: begin
        rdata_d[svtd_pkg::dir_bit] = ctrl_q.dir;
        rdata_d[svtd_pkg::bg_bit] = bandgap_ok;
        rdata_d[svtd_pkg::ref_bit] = stable_q;
        rdata_d[svtd_pkg::en_bit] = ctrl_q.en;
        rdata_d[svtd_pkg::lvl_lo +: svtd_pkg::lvl_w] = ctrl_q.level;
      end
      svtd_pkg::flag_addr: rdata_d[svtd_pkg::evt_bit] = evt_q;
      svtd_pkg::mask_addr: rdata_d[svtd_pkg::evt_bit] = mask_q;
      default: rdata_d = 32'h0000_0000;
    endcase
    ready_d = acc;
    err_d = acc && !hit;
    irq_d = evt_d && mask_d;
    wake_d = evt_d;
    ana_d.power = ctrl_d.en;
    ana_d.use_ext = ctrl_d.level == svtd_pkg::ext_code;
    ana_d.dir = ctrl_d.dir;
    ana_d.level = ctrl_d.level;
  end

  // state registers; reset turns the detector off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= '{dir: svtd_pkg::ctrl_reset[svtd_pkg::dir_bit],
        en: svtd_pkg::ctrl_reset[svtd_pkg::en_bit],
        level: svtd_pkg::ctrl_reset[svtd_pkg::lvl_lo +: svtd_pkg::lvl_w]
      };
      mask_q <= 1'b0;
      cnt_q <= 16'h0000;
      stable_q <= 1'b0;
      evt_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      wake <= 1'b0;
      ana_ctrl <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      stable_q <= stable_d;
      evt_q <= evt_d;
      prdata <= rdata_d;
      pready <= ready_d;
      pslverr <= err_d;
      irq <= irq_d;
      wake <= wake_d;
      ana_ctrl <= ana_d;
    end
  end

  // checks
  // a rise of the enable bit, seen on two edges
  sequence s_power_up;
    !ctrl_q.en ##1 ctrl_q.en;
  endsequence

  // a synchronised trip that the flag may take
  sequence s_trip_taken;
    ctrl_q.en && stable_q && sync2_q;
  endsequence

  // a software clear of the event flag
  sequence s_flag_clear;
    wr && paddr == svtd_pkg::flag_addr && pwdata[svtd_pkg::evt_bit];
  endsequence

  // stable flag starts low on each power-up
  a_ref_low_start: assert property (
    @(posedge clk) disable iff (!nrst)
    s_power_up |-> !stable_q)
    else $error("stable flag high at power-up");

  // no event can be taken before the reference settles
  a_no_early_event: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(evt_q) |-> $past(stable_q))
    else $error("event before stable");

  // a settled trip always reaches the flag
  a_trip_sets_flag: assert property (
    @(posedge clk) disable iff (!nrst)
    s_trip_taken |=> evt_q)
    else $error("trip lost");

  // the flag only drops on a software clear
  a_flag_sticky: assert property (
    @(posedge clk) disable iff (!nrst)
    evt_q && !(wr && paddr == svtd_pkg::flag_addr) |=> evt_q)
    else $error("flag dropped");

  // an unmasked flag raises the interrupt
  a_irq_follows_flag: assert property (
    @(posedge clk) disable iff (!nrst)
    evt_q && mask_q |-> irq)
    else $error("irq missing");

  // the top level code routes the external input
  a_ext_select: assert property (
    @(posedge clk) disable iff (!nrst)
    ana_ctrl.use_ext == (ana_ctrl.level == svtd_pkg::ext_code))
    else $error("external select wrong");

  // analog front end unpowered while disabled
  a_power_off: assert property (
    @(posedge clk) disable iff (!nrst)
    !ctrl_q.en |-> !ana_ctrl.power)
    else $error("powered while off");

  // direction output follows the control bit
  a_dir_drive: assert property (
    @(posedge clk) disable iff (!nrst)
    ana_ctrl.dir == ctrl_q.dir)
    else $error("direction mismatch");

  // level output follows the control field
  a_level_drive: assert property (
    @(posedge clk) disable iff (!nrst)
    ana_ctrl.level == ctrl_q.level)
    else $error("level mismatch");

  // power output follows the enable bit
  a_power_drive: assert property (
    @(posedge clk) disable iff (!nrst)
    ana_ctrl.power == ctrl_q.en)
    else $error("power mismatch");

  // a control write stores the level field
  a_level_write: assert property (
    @(posedge clk) disable iff (!nrst)
    wr && paddr == svtd_pkg::ctrl_addr |=>
    ctrl_q.level == $past(pwdata[svtd_pkg::lvl_lo +: svtd_pkg::lvl_w]))
    else $error("level not stored");

  // a control write stores the direction bit
  a_dir_write: assert property (
    @(posedge clk) disable iff (!nrst)
    wr && paddr == svtd_pkg::ctrl_addr |=>
    ctrl_q.dir == $past(pwdata[svtd_pkg::dir_bit]))
    else $error("direction not stored");

  // bandgap state is read back live
  a_bg_readback: assert property (
    @(posedge clk) disable iff (!nrst)
    pready && !pslverr && $past(paddr == svtd_pkg::ctrl_addr) |->
    prdata[svtd_pkg::bg_bit] == $past(bandgap_ok))
    else $error("bandgap flag wrong");

  // reference state is read back live
  a_ref_readback: assert property (
    @(posedge clk) disable iff (!nrst)
    pready && !pslverr && $past(paddr == svtd_pkg::ctrl_addr) |->
    prdata[svtd_pkg::ref_bit] == $past(stable_q))
    else $error("stable flag wrong");

  // stable flag holds while the detector stays on
  a_ref_holds: assert property (
    @(posedge clk) disable iff (!nrst)
    stable_q && ctrl_q.en |=> stable_q)
    else $error("stable flag dropped");

  // switching off forgets the settled reference
  a_ref_drops: assert property (
    @(posedge clk) disable iff (!nrst)
    !ctrl_q.en |=> !stable_q)
    else $error("stable while off");

  // settling ends exactly at the fixed count
  a_settle_end: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(stable_q) |-> cnt_q == svtd_pkg::settle_max - 16'h0001)
    else $error("settle count wrong");

  // a disabled detector raises no event
  a_off_no_event: assert property (
    @(posedge clk) disable iff (!nrst)
    !ctrl_q.en && !evt_q |=> !evt_q)
    else $error("event while off");

  // a clear drops the flag unless a trip lands with it
  a_flag_clear: assert property (
    @(posedge clk) disable iff (!nrst)
    s_flag_clear |=> evt_q == $past(ctrl_q.en && stable_q && sync2_q))
    else $error("clear misbehaved");

  // wake request mirrors the event flag
  a_wake_follows: assert property (
    @(posedge clk) disable iff (!nrst)
    wake == evt_q)
    else $error("wake mismatch");

  // no interrupt without an unmasked flag
  a_irq_needs_mask: assert property (
    @(posedge clk) disable iff (!nrst)
    irq |-> evt_q && mask_q)
    else $error("spurious irq");

  // second stage copies the first a cycle later
  a_sync_chain: assert property (
    @(posedge clk) disable iff (!nrst)
    sync2_q == $past(sync1_q))
    else $error("synchroniser broken");

  // every access is answered on the next edge
  a_ready_answer: assert property (
    @(posedge clk) disable iff (!nrst)
    acc |=> pready)
    else $error("no ready");

  // ready stands for one cycle only
  a_ready_pulse: assert property (
    @(posedge clk) disable iff (!nrst)
    pready |=> !pready)
    else $error("ready too long");

  // an error only comes with ready
  a_err_ready: assert property (
    @(posedge clk) disable iff (!nrst)
    pslverr |-> pready)
    else $error("error without ready");

  // unmapped reads return zero
  a_err_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule // svtd_top
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [13:0] ca = svtd_pkg::ctrl_addr;
  localparam logic [13:0] fa = svtd_pkg::flag_addr;
  localparam logic [13:0] ma = svtd_pkg::mask_addr;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic cmp_trip = 0, bandgap_ok = 0, er;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, irq, wake;
  svtd_pkg::svtd_ana_type ana;
  int fails = 0, checks = 0;
  // free running system clock
  always #10 clk = ~clk;
  svtd_top u_svtd_top (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_trip(cmp_trip), .bandgap_ok(bandgap_ok), .ana_ctrl(ana),
    .irq(irq), .wake(wake));
  // compare and count
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  // an idle edge follows, so the next setup never meets the release
  task automatic apb(logic w, logic [13:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 0;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // one cycle trip pulse, then time for the synchroniser
  task automatic trip;
    cmp_trip <= 1;
    @(posedge clk);
    cmp_trip <= 0;
    repeat (5) @(posedge clk);
  endtask
  task automatic print_verdict;
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    apb(0, ca, 0);
    chk("ctrl_rst", rd, 0);
    chk("ana_rst", 32'(ana), 0);
    bandgap_ok <= 1;
    apb(1, ca, 32'h6f);
    apb(0, ca, 0);
    chk("ro_bits", rd, 32'h4f);
    chk("ext_sel", 32'(ana.use_ext), 1);
    chk("off", 32'(ana.power), 0);
    apb(1, ca, 32'h83);
    chk("dir", 32'(ana.dir), 1);
    chk("lvl", 32'(ana.level), 3);
    chk("int_sel", 32'(ana.use_ext), 0);
    apb(1, ca, 32'h93);
    chk("on", 32'(ana.power), 1);
    apb(1, fa, 1);
    trip();
    apb(0, ca, 0);
    chk("unsettled", rd, 32'hd3);
    apb(0, fa, 0);
    chk("early_evt", rd, 0);
    apb(1, ma, 1);
    repeat (1000) @(posedge clk);
    apb(0, ca, 0);
    chk("settled", rd, 32'hf3);
    trip();
    chk("irq", 32'(irq), 1);
    chk("wake", 32'(wake), 1);
    repeat (20) @(posedge clk);
    apb(0, fa, 0);
    chk("sticky", rd, 1);
    apb(1, fa, 1);
    apb(0, fa, 0);
    chk("clr", rd, 0);
    chk("irq_clr", 32'(irq), 0);
    apb(1, ma, 0);
    trip();
    chk("masked", 32'(irq), 0);
    chk("wake_m", 32'(wake), 1);
    apb(1, 14'h0000, 32'hff);
    chk("err", 32'(er), 1);
    apb(1, ca, 32'h03);
    chk("off_again", 32'(ana.power), 0);
    nrst <= 0;
    @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    apb(0, ca, 0);
    chk("ctrl_rst2", rd, 32'h40);
    chk("off2", 32'(ana.power), 0);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
